// ===== verilog/dcfm_pkg.sv
package dcfm_pkg;

  // Queue geometry
  localparam int DCFM_DEPTH = 512;
  localparam int DCFM_AW = 9;
  localparam int DCFM_PW = DCFM_AW + 1;
  localparam int DCFM_DW = 36;
  localparam logic [DCFM_PW-1:0] DCFM_FULL_COUNT = 10'h200;

  // Offset limits and presets chosen by the two select straps
  localparam logic [DCFM_AW-1:0] DCFM_OFS_MIN = 9'h001;
  localparam logic [DCFM_AW-1:0] DCFM_OFS_MAX = 9'h1FC;
  localparam logic [DCFM_AW-1:0] DCFM_PRESET_01 = 9'h010;
  localparam logic [DCFM_AW-1:0] DCFM_PRESET_10 = 9'h040;
  localparam logic [DCFM_AW-1:0] DCFM_PRESET_11 = 9'h008;

  // Wishbone register map (byte addresses)
  localparam logic [7:0] DCFM_ADR_STATUS = 8'h00;
  localparam logic [7:0] DCFM_ADR_OFS_AB = 8'h04;
  localparam logic [7:0] DCFM_ADR_OFS_BA = 8'h08;

  // Offset register fields
  localparam int DCFM_FULL_LSB = 0;
  localparam int DCFM_EMPTY_LSB = 16;

  // Status register fields
  localparam int DCFM_ST_A_IN_READY = 0;
  localparam int DCFM_ST_A_OUT_READY = 1;
  localparam int DCFM_ST_A_AE_N = 2;
  localparam int DCFM_ST_A_AF_N = 3;
  localparam int DCFM_ST_B_IN_READY = 4;
  localparam int DCFM_ST_B_OUT_READY = 5;
  localparam int DCFM_ST_B_AE_N = 6;
  localparam int DCFM_ST_B_AF_N = 7;
  localparam int DCFM_ST_AB_MAIL_N = 8;
  localparam int DCFM_ST_BA_MAIL_N = 9;
  localparam int DCFM_ST_PROG_DONE = 10;

  typedef enum logic [2:0] {
    DCFM_PRG_AB_FULL = 3'b000,
    DCFM_PRG_AB_EMPTY = 3'b001,
    DCFM_PRG_BA_FULL = 3'b010,
    DCFM_PRG_BA_EMPTY = 3'b011,
    DCFM_PRG_DONE = 3'b100
  } dcfm_prog_t;

endpackage

// ===== verilog/dcfm_fifo_mailbox.sv
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dcfm_fifo_mailbox
  import dcfm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Reset-time offset preset selects
  input wire logic flag_preset_select_low_i,
  input wire logic flag_preset_select_high_i,
  // Port A control
  input wire logic porta_chip_select_n_i,
  input wire logic porta_write_not_read_i,
  input wire logic porta_enable_i,
  input wire logic porta_mailbox_select_i,
  // Port A data pins
  input wire logic [DCFM_DW-1:0] porta_data_i,
  output logic [DCFM_DW-1:0] porta_data_o,
  output logic porta_data_oe_o,
  // Port A flags
  output logic porta_in_ready_o,
  output logic porta_out_ready_o,
  output logic porta_almost_empty_n_o,
  output logic porta_almost_full_n_o,
  // Port B control
  input wire logic portb_chip_select_n_i,
  input wire logic portb_read_not_write_i,
  input wire logic portb_enable_i,
  input wire logic portb_mailbox_select_i,
  // Port B data pins
  input wire logic [DCFM_DW-1:0] portb_data_i,
  output logic [DCFM_DW-1:0] portb_data_o,
  output logic portb_data_oe_o,
  // Port B flags
  output logic portb_in_ready_o,
  output logic portb_out_ready_o,
  output logic portb_almost_empty_n_o,
  output logic portb_almost_full_n_o,
  // Mailbox flags
  output logic a_to_b_mail_full_n_o,
  output logic b_to_a_mail_full_n_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // Index 0 is the a_to_b_queue, index 1 the b_to_a_queue
  typedef struct packed {
    logic [1:0][DCFM_PW-1:0] wptr;
    logic [1:0][DCFM_PW-1:0] rptr;
    logic [1:0][DCFM_PW-1:0] wsync1;
    logic [1:0][DCFM_PW-1:0] wsync2;
    logic [1:0][DCFM_PW-1:0] rsync1;
    logic [1:0][DCFM_DW-1:0] outq;
    logic [1:0][DCFM_DW-1:0] mail;
    logic [1:0] out_ready;
    logic [1:0] in_ready;
    logic [1:0] ae_n;
    logic [1:0] af_n;
    logic [1:0] mail_full_n;
    logic [1:0][DCFM_AW-1:0] empty_ofs;
    logic [1:0][DCFM_AW-1:0] full_ofs;
    dcfm_prog_t prog;
    logic wb_ack;
    logic [31:0] wb_dat;
  } dcfm_state_t;

  dcfm_state_t state_reg;
  dcfm_state_t state_next;

  logic [DCFM_DW-1:0] mem [0:1][0:DCFM_DEPTH-1];

  logic [1:0] wr_req;
  logic [1:0] rd_req;
  logic [1:0] mb_wr;
  logic [1:0] mb_rd;
  logic [1:0] mem_we;
  logic [1:0][DCFM_DW-1:0] wr_data;

  function automatic logic [31:0] dcfm_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] dcfm_ofs_word(input logic [DCFM_AW-1:0] full_v,
                                                input logic [DCFM_AW-1:0] empty_v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[DCFM_FULL_LSB +: DCFM_AW] = full_v;
    w[DCFM_EMPTY_LSB +: DCFM_AW] = empty_v;
    return w;
  endfunction

  // Port decode: port A writes the a_to_b side, port B the b_to_a side
  logic port_a_wr;
  logic port_a_rd;
  logic port_b_wr;
  logic port_b_rd;

  always_comb begin
    port_a_wr = !porta_chip_select_n_i && porta_write_not_read_i && porta_enable_i;
    port_a_rd = !porta_chip_select_n_i && !porta_write_not_read_i && porta_enable_i;
    port_b_wr = !portb_chip_select_n_i && !portb_read_not_write_i && portb_enable_i;
    port_b_rd = !portb_chip_select_n_i && portb_read_not_write_i && portb_enable_i;
    wr_req[0] = port_a_wr && !porta_mailbox_select_i;
    wr_req[1] = port_b_wr && !portb_mailbox_select_i;
    rd_req[0] = port_b_rd && !portb_mailbox_select_i;
    rd_req[1] = port_a_rd && !porta_mailbox_select_i;
    mb_wr[0] = port_a_wr && porta_mailbox_select_i;
    mb_wr[1] = port_b_wr && portb_mailbox_select_i;
    mb_rd[0] = port_b_rd && portb_mailbox_select_i;
    mb_rd[1] = port_a_rd && porta_mailbox_select_i;
    wr_data[0] = porta_data_i;
    wr_data[1] = portb_data_i;
  end

  logic [DCFM_PW-1:0] fill_w;
  logic [DCFM_PW-1:0] fill_r;
  logic [DCFM_PW-1:0] full_mark;
  logic load;
  logic prog_wr;
  logic wb_req;
  logic [31:0] ofs_w;

  always_comb begin
    state_next = state_reg;
    mem_we = 2'b00;
    fill_w = '0;
    fill_r = '0;
    full_mark = '0;
    load = 1'b0;
    ofs_w = 32'h0000_0000;
    // Offset loading through port A replaces a_to_b data writes
    prog_wr = wr_req[0] && state_reg.in_ready[0] && (state_reg.prog != DCFM_PRG_DONE);
    case (state_reg.prog)
      DCFM_PRG_AB_FULL: begin
        if (prog_wr) begin
          state_next.full_ofs[0] = porta_data_i[DCFM_AW-1:0];
          state_next.prog = DCFM_PRG_AB_EMPTY;
        end
      end
      DCFM_PRG_AB_EMPTY: begin
        if (prog_wr) begin
          state_next.empty_ofs[0] = porta_data_i[DCFM_AW-1:0];
          state_next.prog = DCFM_PRG_BA_FULL;
        end
      end
      DCFM_PRG_BA_FULL: begin
        if (prog_wr) begin
          state_next.full_ofs[1] = porta_data_i[DCFM_AW-1:0];
          state_next.prog = DCFM_PRG_BA_EMPTY;
        end
      end
      DCFM_PRG_BA_EMPTY: begin
        if (prog_wr) begin
          state_next.empty_ofs[1] = porta_data_i[DCFM_AW-1:0];
          state_next.prog = DCFM_PRG_DONE;
        end
      end
      DCFM_PRG_DONE: begin
      end
      default: begin
        state_next.prog = DCFM_PRG_DONE;
      end
    endcase

    for (int q = 0; q < 2; q++) begin
      // Write side
      if (wr_req[q] && state_reg.in_ready[q] && !(q == 0 && prog_wr)) begin
        mem_we[q] = 1'b1;
        state_next.wptr[q] = state_reg.wptr[q] + 10'h001;
      end
      // Read side: pointer copies cross one stage per edge
      state_next.wsync1[q] = state_reg.wptr[q];
      state_next.wsync2[q] = state_reg.wsync1[q];
      state_next.rsync1[q] = state_reg.rptr[q];
      load = (state_reg.wsync2[q] != state_reg.rptr[q]) &&
             (!state_reg.out_ready[q] || rd_req[q]);
      if (load) begin
        state_next.outq[q] = mem[q][state_reg.rptr[q][DCFM_AW-1:0]];
        state_next.rptr[q] = state_reg.rptr[q] + 10'h001;
        state_next.out_ready[q] = 1'b1;
      end else if (rd_req[q] && state_reg.out_ready[q]) begin
        state_next.out_ready[q] = 1'b0;
      end
      // Writer-side flags see reads one stage late
      fill_w = state_next.wptr[q] - state_reg.rsync1[q];
      full_mark = DCFM_FULL_COUNT - {1'b0, state_reg.full_ofs[q]};
      state_next.in_ready[q] = (fill_w != DCFM_FULL_COUNT) &&
                               (q == 0 || state_next.prog == DCFM_PRG_DONE);
      state_next.af_n[q] = fill_w < full_mark;
      // Reader-side almost-empty counts memory words only
      fill_r = state_reg.wsync1[q] - state_next.rptr[q];
      state_next.ae_n[q] = fill_r > {1'b0, state_reg.empty_ofs[q]};
      // Mailboxes: a write while full is dropped, a new write beats a release
      if (mb_wr[q] && state_reg.mail_full_n[q]) begin
        state_next.mail[q] = wr_data[q];
        state_next.mail_full_n[q] = 1'b0;
      end else if (mb_rd[q]) begin
        state_next.mail_full_n[q] = 1'b1;
      end
    end

    // Wishbone slave: ack one cycle after the request, dropped the next
    wb_req = wb_cyc_i && wb_stb_i && !state_reg.wb_ack;
    state_next.wb_ack = wb_req;
    state_next.wb_dat = 32'h0000_0000;
    if (wb_req) begin
      case (wb_adr_i)
        DCFM_ADR_STATUS: begin
          state_next.wb_dat[DCFM_ST_A_IN_READY] = state_reg.in_ready[0];
          state_next.wb_dat[DCFM_ST_A_OUT_READY] = state_reg.out_ready[1];
          state_next.wb_dat[DCFM_ST_A_AE_N] = state_reg.ae_n[1];
          state_next.wb_dat[DCFM_ST_A_AF_N] = state_reg.af_n[0];
          state_next.wb_dat[DCFM_ST_B_IN_READY] = state_reg.in_ready[1];
          state_next.wb_dat[DCFM_ST_B_OUT_READY] = state_reg.out_ready[0];
          state_next.wb_dat[DCFM_ST_B_AE_N] = state_reg.ae_n[0];
          state_next.wb_dat[DCFM_ST_B_AF_N] = state_reg.af_n[1];
          state_next.wb_dat[DCFM_ST_AB_MAIL_N] = state_reg.mail_full_n[0];
          state_next.wb_dat[DCFM_ST_BA_MAIL_N] = state_reg.mail_full_n[1];
          state_next.wb_dat[DCFM_ST_PROG_DONE] = state_reg.prog == DCFM_PRG_DONE;
        end
        DCFM_ADR_OFS_AB, DCFM_ADR_OFS_BA: begin
          if (wb_adr_i == DCFM_ADR_OFS_AB) begin
            ofs_w = dcfm_ofs_word(state_reg.full_ofs[0], state_reg.empty_ofs[0]);
          end else begin
            ofs_w = dcfm_ofs_word(state_reg.full_ofs[1], state_reg.empty_ofs[1]);
          end
          state_next.wb_dat = ofs_w;
          if (wb_we_i) begin
            ofs_w = dcfm_merge(ofs_w, wb_dat_i, wb_sel_i);
            if (wb_adr_i == DCFM_ADR_OFS_AB) begin
              state_next.full_ofs[0] = ofs_w[DCFM_FULL_LSB +: DCFM_AW];
              state_next.empty_ofs[0] = ofs_w[DCFM_EMPTY_LSB +: DCFM_AW];
            end else begin
              state_next.full_ofs[1] = ofs_w[DCFM_FULL_LSB +: DCFM_AW];
              state_next.empty_ofs[1] = ofs_w[DCFM_EMPTY_LSB +: DCFM_AW];
            end
          end
        end
        default: begin
          state_next.wb_dat = 32'h0000_0000;
        end
      endcase
    end
  end

  logic [DCFM_AW-1:0] preset_ofs;

  always_comb begin
    case ({flag_preset_select_high_i, flag_preset_select_low_i})
      2'b01: preset_ofs = DCFM_PRESET_01;
      2'b10: preset_ofs = DCFM_PRESET_10;
      2'b11: preset_ofs = DCFM_PRESET_11;
      default: preset_ofs = DCFM_OFS_MIN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.af_n <= 2'b11;
      state_reg.mail_full_n <= 2'b11;
      state_reg.empty_ofs <= {preset_ofs, preset_ofs};
      state_reg.full_ofs <= {preset_ofs, preset_ofs};
      if (!flag_preset_select_low_i && !flag_preset_select_high_i) begin
        state_reg.prog <= DCFM_PRG_AB_FULL;
      end else begin
        state_reg.prog <= DCFM_PRG_DONE;
      end
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int q = 0; q < 2; q++) begin
      if (mem_we[q]) begin
        mem[q][state_reg.wptr[q][DCFM_AW-1:0]] <= wr_data[q];
      end
    end
  end

  // Pins and flags
  always_comb begin
    porta_data_oe_o = !porta_chip_select_n_i && !porta_write_not_read_i;
    portb_data_oe_o = !portb_chip_select_n_i && portb_read_not_write_i;
    porta_data_o = porta_mailbox_select_i ? state_reg.mail[1] : state_reg.outq[1];
    portb_data_o = portb_mailbox_select_i ? state_reg.mail[0] : state_reg.outq[0];
    porta_in_ready_o = state_reg.in_ready[0];
    porta_almost_full_n_o = state_reg.af_n[0];
    porta_out_ready_o = state_reg.out_ready[1];
    porta_almost_empty_n_o = state_reg.ae_n[1];
    portb_in_ready_o = state_reg.in_ready[1];
    portb_almost_full_n_o = state_reg.af_n[1];
    portb_out_ready_o = state_reg.out_ready[0];
    portb_almost_empty_n_o = state_reg.ae_n[0];
    a_to_b_mail_full_n_o = state_reg.mail_full_n[0];
    b_to_a_mail_full_n_o = state_reg.mail_full_n[1];
    wb_dat_o = state_reg.wb_dat;
    wb_ack_o = state_reg.wb_ack;
  end

endmodule

// ===== tb/dcfm_props.sv
`timescale 1ns/1ps
module dcfm_props
  import dcfm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Port A
  input wire logic porta_chip_select_n_i,
  input wire logic porta_write_not_read_i,
  input wire logic porta_enable_i,
  input wire logic porta_mailbox_select_i,
  input wire logic porta_in_ready_o,
  // Port B
  input wire logic portb_chip_select_n_i,
  input wire logic portb_read_not_write_i,
  input wire logic portb_enable_i,
  input wire logic portb_mailbox_select_i,
  input wire logic [DCFM_DW-1:0] portb_data_o,
  input wire logic portb_in_ready_o,
  input wire logic portb_out_ready_o,
  input wire logic a_to_b_mail_full_n_o,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  wire wr_a = !porta_chip_select_n_i && porta_write_not_read_i && porta_enable_i;
  wire qa_wr = wr_a && !porta_mailbox_select_i && porta_in_ready_o;
  wire mb_ld = wr_a && porta_mailbox_select_i && a_to_b_mail_full_n_o;
  wire rd_b = !portb_chip_select_n_i && portb_read_not_write_i && portb_enable_i;
  wire qb_rd = rd_b && !portb_mailbox_select_i && portb_out_ready_o;
  wire mb_rd = rd_b && portb_mailbox_select_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Empty queue: no write for three edges
  sequence quiet_a; (!qa_wr)[*3]; endsequence
  sequence land_b; (!portb_out_ready_o)[*3] ##1 portb_out_ready_o; endsequence
  chk_fall_through: assert property (
    quiet_a ##1 (qa_wr && !portb_out_ready_o && portb_in_ready_o) |=> land_b)
    else $error("first word landed at the wrong edge");
  chk_ir_rise: assert property (
    qb_rd && !porta_in_ready_o && !$past(qb_rd) && !$past(qb_rd, 2)
    |=> !porta_in_ready_o ##1 !porta_in_ready_o ##1 porta_in_ready_o)
    else $error("input ready did not rise two edges after read");
  chk_ir_hold: assert property (
    !porta_in_ready_o && !qb_rd && !$past(qb_rd) && !$past(qb_rd, 2) && !$past(rst_i)
    |=> !porta_in_ready_o) else $error("input ready rose without a read");
  chk_mail_set: assert property (mb_ld |=> !a_to_b_mail_full_n_o)
    else $error("mail flag not lowered by write");
  chk_mail_clear: assert property (mb_rd && !mb_ld |=> a_to_b_mail_full_n_o)
    else $error("mail flag not raised by read");
  chk_mail_keep: assert property (
    portb_mailbox_select_i && $past(portb_mailbox_select_i) && !$past(mb_ld) && !$past(rst_i)
    |-> $stable(portb_data_o)) else $error("mailbox changed without a write");
  chk_out_hold: assert property (
    !portb_out_ready_o && !portb_mailbox_select_i && !$past(portb_mailbox_select_i)
    && !$past(rst_i) |-> $stable(portb_data_o)) else $error("stale output word changed");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_delay: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
endmodule

bind dcfm_fifo_mailbox dcfm_props props_u (.clk_i(clk_i), .rst_i(rst_i),
  .porta_chip_select_n_i(porta_chip_select_n_i), .porta_write_not_read_i(porta_write_not_read_i),
  .porta_enable_i(porta_enable_i), .porta_mailbox_select_i(porta_mailbox_select_i),
  .porta_in_ready_o(porta_in_ready_o), .portb_chip_select_n_i(portb_chip_select_n_i),
  .portb_read_not_write_i(portb_read_not_write_i), .portb_enable_i(portb_enable_i),
  .portb_mailbox_select_i(portb_mailbox_select_i), .portb_data_o(portb_data_o),
  .portb_in_ready_o(portb_in_ready_o), .portb_out_ready_o(portb_out_ready_o),
  .a_to_b_mail_full_n_o(a_to_b_mail_full_n_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o));

// ===== tb/dcfm_port_model.sv
`timescale 1ns/1ps
module dcfm_port_model
  import dcfm_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Data from the device
  input wire logic [DCFM_DW-1:0] dev_data_i,
  // Port controls
  output logic chip_select_n_o,
  output logic dir_o,
  output logic enable_o,
  output logic mailbox_select_o,
  output logic [DCFM_DW-1:0] data_o
);
  initial begin
    chip_select_n_o = 1'b1;
    dir_o = 1'b1;
    enable_o = 1'b0;
    mailbox_select_o = 1'b0;
    data_o = '0;
  end
  // Held through the taking edge; read data taken at that edge
  task automatic xfer(input logic dir, input logic mb, input logic [DCFM_DW-1:0] wd,
                      output logic [DCFM_DW-1:0] rd);
    chip_select_n_o <= 1'b0;
    dir_o <= dir;
    enable_o <= 1'b1;
    mailbox_select_o <= mb;
    data_o <= wd;
    @(posedge clk_i);
    rd = dev_data_i;
  endtask
  // Released bus shows the inverse of the last word
  task automatic idle();
    chip_select_n_o <= 1'b1;
    enable_o <= 1'b0;
    mailbox_select_o <= 1'b0;
    data_o <= ~data_o;
    @(posedge clk_i);
  endtask
endmodule

// ===== tb/dual_clock_fifo_flags_mailbox_tb_top.sv
`timescale 1ns/1ps
module dual_clock_fifo_flags_mailbox_tb_top;
  import dcfm_pkg::*;
  localparam logic [8:0] OFS [4] = '{9'h004, 9'h002, 9'h005, 9'h003};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] fsel = 2'b00;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, dat_r, wbr;
  logic a_cs_n, a_wnr, a_en, a_mb, b_cs_n, b_rnw, b_en, b_mb;
  logic a_oe, a_ir, a_or, a_ae, a_af, b_oe, b_ir, b_or, b_ae, b_af, mf_ab, mf_ba;
  logic [DCFM_DW-1:0] a_di, a_do, b_di, b_do, rd;
  int fails = 0, checked = 0, n;
  initial forever #20 clk_i = ~clk_i;
  dcfm_fifo_mailbox dut_u (.clk_i(clk_i), .rst_i(rst_i), .flag_preset_select_low_i(fsel[0]),
    .flag_preset_select_high_i(fsel[1]), .porta_chip_select_n_i(a_cs_n),
    .porta_write_not_read_i(a_wnr), .porta_enable_i(a_en), .porta_mailbox_select_i(a_mb),
    .porta_data_i(a_di), .porta_data_o(a_do), .porta_data_oe_o(a_oe), .porta_in_ready_o(a_ir),
    .porta_out_ready_o(a_or), .porta_almost_empty_n_o(a_ae), .porta_almost_full_n_o(a_af),
    .portb_chip_select_n_i(b_cs_n), .portb_read_not_write_i(b_rnw), .portb_enable_i(b_en),
    .portb_mailbox_select_i(b_mb), .portb_data_i(b_di), .portb_data_o(b_do),
    .portb_data_oe_o(b_oe), .portb_in_ready_o(b_ir), .portb_out_ready_o(b_or),
    .portb_almost_empty_n_o(b_ae), .portb_almost_full_n_o(b_af), .a_to_b_mail_full_n_o(mf_ab),
    .b_to_a_mail_full_n_o(mf_ba), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_r), .wb_ack_o(ack));
  dcfm_port_model pa_u (.clk_i(clk_i), .dev_data_i(a_do), .chip_select_n_o(a_cs_n),
    .dir_o(a_wnr), .enable_o(a_en), .mailbox_select_o(a_mb), .data_o(a_di));
  dcfm_port_model pb_u (.clk_i(clk_i), .dev_data_i(b_do), .chip_select_n_o(b_cs_n),
    .dir_o(b_rnw), .enable_o(b_en), .mailbox_select_o(b_mb), .data_o(b_di));
  task automatic check(input logic [DCFM_DW-1:0] seen, input logic [DCFM_DW-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [DCFM_DW-1:0] mkw(input int k, input logic [3:0] t);
    return {t, 32'(k)};
  endfunction
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (t >= 20) fails++;
    wbr = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Whole run is under two thousand cycles
  initial begin
    #160000;
    fails++;
    end_of_test();
  end
  initial begin
    tick(5);
    check(36'({a_or, b_or, a_ae, b_ae, a_af, b_af, mf_ab, mf_ba, b_ir}), 36'h01E);
    rst_i <= 1'b0;
    tick(2);
    check(36'(b_ir), 36'h0);
    for (int i = 0; i < 4; i++) begin
      pa_u.xfer(1'b1, 1'b0, 36'(OFS[i]), rd);
      pa_u.idle();
    end
    tick(1);
    check(36'(b_ir), 36'h1);
    wb(1'b0, DCFM_ADR_OFS_AB, 32'h0);
    check(36'(wbr), 36'h000020004);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF);
    wb(1'b0, 8'h0C, 32'h0);
    check(36'(wbr), 36'h0);
    wb(1'b0, DCFM_ADR_OFS_BA, 32'h0);
    check(36'(wbr), 36'h000030005);
    $display("offset test done");
    pa_u.xfer(1'b1, 1'b0, mkw(1, 4'hA), rd);
    pa_u.idle();
    tick(2);
    check(36'(b_or), 36'h0);
    tick(1);
    check(36'(b_or), 36'h1);
    check(b_do, mkw(1, 4'hA));
    for (int k = 2; k < 5; k++) pa_u.xfer(1'b1, 1'b0, mkw(k, 4'hA), rd);
    pa_u.idle();
    check(36'(b_ae), 36'h0);
    tick(1);
    check(36'(b_ae), 36'h0);
    tick(1);
    check(36'(b_ae), 36'h1);
    for (int k = 1; k < 5; k++) begin
      pb_u.xfer(1'b1, 1'b0, '0, rd);
      check(rd, mkw(k, 4'hA));
    end
    pb_u.xfer(1'b1, 1'b0, '0, rd);
    pb_u.idle();
    check(36'(b_or), 36'h0);
    check(b_do, mkw(4, 4'hA));
    $display("fall-through test done");
    n = 0;
    for (int i = 0; i < 520; i++) begin
      pa_u.xfer(1'b1, 1'b0, mkw(i, 4'h5), rd);
      if (a_ir === 1'b1) n++;
    end
    pa_u.idle();
    check(36'(n), 36'h201);
    check(36'({a_ir, a_af}), 36'h0);
    for (int i = 0; i < 5; i++) begin
      pb_u.xfer(1'b1, 1'b0, '0, rd);
      check(rd, mkw(i, 4'h5));
      if (i == 0) begin
        pb_u.idle();
        check(36'(a_ir), 36'h0);
        tick(1);
        check(36'(a_ir), 36'h0);
        tick(1);
        check(36'(a_ir), 36'h1);
      end
    end
    pb_u.idle();
    check(36'(a_af), 36'h0);
    tick(1);
    check(36'(a_af), 36'h0);
    tick(1);
    check(36'(a_af), 36'h1);
    for (int i = 5; i < 513; i++) begin
      pb_u.xfer(1'b1, 1'b0, '0, rd);
      check(rd, mkw(i, 4'h5));
    end
    pb_u.idle();
    check(36'(b_or), 36'h0);
    $display("fill test done");
    for (int k = 1; k < 6; k++) pb_u.xfer(1'b0, 1'b0, mkw(k, 4'hB), rd);
    pb_u.idle();
    tick(4);
    check(36'({a_or, a_ae, b_af, b_ir}), 36'hF);
    for (int k = 1; k < 6; k++) begin
      pa_u.xfer(1'b0, 1'b0, '0, rd);
      check(rd, mkw(k, 4'hB));
    end
    pa_u.idle();
    check(36'({a_or, a_ae}), 36'h0);
    $display("reverse queue test done");
    pa_u.xfer(1'b1, 1'b1, mkw(1, 4'hC), rd);
    check(36'(a_oe), 36'h0);
    pa_u.xfer(1'b1, 1'b1, mkw(2, 4'hC), rd);
    pa_u.idle();
    check(36'(mf_ab), 36'h0);
    pb_u.xfer(1'b1, 1'b1, '0, rd);
    check(rd, mkw(1, 4'hC));
    check(36'(b_oe), 36'h1);
    pb_u.xfer(1'b1, 1'b1, '0, rd);
    check(rd, mkw(1, 4'hC));
    pb_u.idle();
    check(36'(mf_ab), 36'h1);
    pb_u.xfer(1'b0, 1'b1, mkw(3, 4'hC), rd);
    check(36'(b_oe), 36'h0);
    pb_u.idle();
    check(36'(mf_ba), 36'h0);
    pa_u.xfer(1'b0, 1'b1, '0, rd);
    check(rd, mkw(3, 4'hC));
    check(36'(a_oe), 36'h1);
    pa_u.idle();
    check(36'(mf_ba), 36'h1);
    $display("mailbox test done");
    wb(1'b0, DCFM_ADR_STATUS, 32'h0);
    check(36'(wbr), 36'h000000799);
    // Second reset with a preset strap: no programming phase
    fsel <= 2'b01;
    rst_i <= 1'b1;
    tick(5);
    rst_i <= 1'b0;
    tick(2);
    check(36'({b_ir, b_or, a_or}), 36'h4);
    wb(1'b0, DCFM_ADR_OFS_BA, 32'h0);
    check(36'(wbr), 36'h000100010);
    $display("preset reset test done");
    end_of_test();
  end
endmodule
